/* File: conv_engine_model.sv */
// conversion engine stand-in: answers each start pulse with one result unless an abort cancels it first
// assumes start and abort are one-cycle pulses from the block under test
`default_nettype none

module conv_engine_model (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // requests from the block
   input  wire logic                         convStart,
   input  wire logic                         convAbort,
   // sample to return and delay in cycles, at least 1
   input  wire logic [15:0]                  sampleTemp,
   input  wire logic [7:0]                   latency,
   // result
   output var temp_alarm_pkg::conv_result_t  convResult
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0]  cnt_q;
   logic [15:0] last_q;

   always @(posedge clk) begin
      convResult.valid <= 1'b0;
      // no stale sample is left on the result lines between answers
      convResult.temp  <= ~last_q;
      if (!rst_n) begin
         cnt_q  <= 8'h00;
         last_q <= 16'h0000;
      end else if (convAbort) begin
         cnt_q <= 8'h00;
      end else if (convStart) begin
         cnt_q <= latency;
      end else if (cnt_q == 8'h01) begin
         convResult.valid <= 1'b1;
         convResult.temp  <= sampleTemp;
         last_q           <= sampleTemp;
         cnt_q            <= 8'h00;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

`default_nettype wire

/* File: period_timer.sv */
// conversion period timer: one pulse per selected period while running
// assumes run drops for at least one cycle between separate sessions
`include "temp_alarm_defines.svh"
`default_nettype none

module period_timer #(
   parameter int TICK_CYCLES = `TA_BASE_CYCLES
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       run,
   input  wire logic [3:0] periodCode,
   // event
   output logic            periodTick
);

   localparam int PRE_W = $clog2(TICK_CYCLES + 1);

   logic [PRE_W-1:0]          preCnt_q,  preCnt_d;
   logic [`TA_TICK_CNT_W-1:0] tickCnt_q, tickCnt_d;
   logic                      periodTick_d;
   logic                      baseTick;

   // number of base ticks per period: 64 s down to 0.25 s, then 0.125 s
   function automatic logic [`TA_TICK_CNT_W-1:0] ticks_for_code(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `TA_CODE_FASTEST) ? `TA_CODE_FASTEST : code;
      ticks_for_code = `TA_TICK_CNT_W'(1) << (`TA_CODE_FASTEST - c);
   endfunction

   assign baseTick = (preCnt_q == PRE_W'(TICK_CYCLES - 1));

   always_comb begin
      preCnt_d     = preCnt_q;
      tickCnt_d    = tickCnt_q;
      periodTick_d = 1'b0;
      if (!run) begin
         preCnt_d  = '0;
         tickCnt_d = '0;
      end else if (baseTick) begin
         preCnt_d = '0;
         if (tickCnt_q + `TA_TICK_CNT_W'(1) >= ticks_for_code(periodCode)) begin
            tickCnt_d    = '0;
            periodTick_d = 1'b1;
         end else begin
            tickCnt_d = tickCnt_q + `TA_TICK_CNT_W'(1);
         end
      end else begin
         preCnt_d = preCnt_q + PRE_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         preCnt_q  <= '0;
         tickCnt_q <= '0;
      end else begin
         preCnt_q  <= preCnt_d;
         tickCnt_q <= tickCnt_d;
      end
   end

   // tick straight from the counters: the registered start that follows it then
   // lands exactly one period after the previous start, the first one included
   assign periodTick = periodTick_d;

endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the alarm-style and conversion-period block
// assumes the design package and the conversion engine model are compiled first
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int TICKS = 8;

   logic                          clk;
   logic                          rst_n;
   temp_alarm_pkg::reg_req_t      regReq;
   logic [7:0]                    rdData;
   logic [15:0]                   hiThreshold;
   logic [15:0]                   loThreshold;
   temp_alarm_pkg::conv_result_t  convResult;
   logic                          convStart;
   logic                          convAbort;
   logic                          highAlarmFlag;
   logic                          lowAlarmFlag;
   logic                          alarmIrq;
   logic [15:0]                   sampleTemp;
   logic [7:0]                    latency;
   logic [7:0]                    v;
   logic [15:0]                   corner [4];
   int                            err_total;
   int                            checks_done;
   int                            seed;
   int                            n;

   temp_alarm_mode_and_period #(.TICK_CYCLES(TICKS), .TRIP_COUNT(3'h1)) dut (
      .clk(clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
      .hiThreshold(hiThreshold), .loThreshold(loThreshold), .convResult(convResult),
      .convStart(convStart), .convAbort(convAbort), .highAlarmFlag(highAlarmFlag),
      .lowAlarmFlag(lowAlarmFlag), .alarmIrq(alarmIrq));

   conv_engine_model engine (
      .clk(clk), .rst_n(rst_n), .convStart(convStart), .convAbort(convAbort),
      .sampleTemp(sampleTemp), .latency(latency), .convResult(convResult));

   always #50 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one idle cycle after each access keeps strobe edges apart
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      regReq.wr    = 1'b1;
      regReq.addr  = addr;
      regReq.wdata = data;
      @(posedge clk);
      @(negedge clk);
      regReq.wr = 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      regReq.rd   = 1'b1;
      regReq.addr = addr;
      @(posedge clk);
      @(negedge clk);
      regReq.rd = 1'b0;
      data      = rdData;
   endtask

   task automatic wait_start(input int limit, output int cyc);
      cyc = 0;
      while (convStart !== 1'b1 && cyc < limit) begin
         @(negedge clk);
         cyc++;
      end
   endtask

   // next result, then let the flags settle
   task automatic wait_result();
      int k;
      k = 0;
      @(negedge clk);
      while (convResult.valid !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      repeat (2) @(negedge clk);
   endtask

   function automatic logic [1:0] exp_flags(input logic [15:0] t);
      exp_flags = {$signed(t) < $signed(loThreshold), $signed(t) > $signed(hiThreshold)};
   endfunction

   function automatic int period_cycles(input int code);
      period_cycles = TICKS << (9 - ((code > 9) ? 9 : code));
   endfunction

   initial begin
      #(100 * 40000);
      err_total++;
      give_verdict();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      regReq = '0;
      hiThreshold = 16'h0064;
      loThreshold = 16'hff9c;
      sampleTemp = 16'h0000;
      latency = 8'h01;
      err_total = 0;
      checks_done = 0;
      seed = 32'h5f589cac;
      corner = '{16'h0064, 16'h0065, 16'hff9c, 16'hff9b};
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      reg_read(8'h29, v);
      check("cfg reset", v, 8'h00);
      check("irq reset", alarmIrq, 1'b0);
      for (int i = 0; i < 8; i++) begin
         logic [7:0] w;
         w = 8'($random(seed));
         reg_write(8'h29, w);
         reg_read(8'h29, v);
         check("cfg readback", v, w & 8'h8f);
      end
      reg_write(8'h29, 8'h70);
      reg_read(8'h29, v);
      check("cfg spare bits", v, 8'h00);
      reg_read(8'h55, v);
      check("unmapped read", v, 8'h00);
      // style bit set but single conversions: interrupt style still applies
      reg_write(8'h29, 8'h80);
      for (int i = 0; i < 10; i++) begin
         logic [15:0] t;
         logic [1:0]  e;
         t = (i < 4) ? corner[i] : 16'($random(seed));
         e = exp_flags(t);
         sampleTemp = t;
         reg_write(8'h2a, 8'h01);
         wait_result();
         check("high flag", highAlarmFlag, e[0]);
         check("low flag", lowAlarmFlag, e[1]);
         check("irq", alarmIrq, |e);
         reg_read(8'h00, v);
         check("status", v[3:2], e);
         @(negedge clk);
         check("cleared", {lowAlarmFlag, highAlarmFlag, alarmIrq}, 3'h0);
      end
      reg_read(8'h2a, v);
      check("single done", v[1:0], 2'h0);
      // comparator style, running continuously
      latency = 8'h02;
      // cumulative trip styles, which comparator style must ignore
      reg_write(8'h20, 8'h08);
      reg_write(8'h21, 8'h08);
      reg_read(8'h20, v);
      check("trip style", v, 8'h08);
      reg_write(8'h02, 8'h00);
      reg_write(8'h29, 8'h88);
      sampleTemp = 16'h00c8;
      reg_write(8'h2a, 8'h03);
      wait_result();
      check("cmp high no enable", {highAlarmFlag, alarmIrq}, 2'h2);
      reg_write(8'h02, 8'h04);
      wait_result();
      check("cmp irq", {highAlarmFlag, alarmIrq}, 2'h3);
      reg_read(8'h00, v);
      check("cmp status", v[3:2], 2'h1);
      @(negedge clk);
      check("cmp kept", {highAlarmFlag, alarmIrq}, 2'h3);
      sampleTemp = 16'h0000;
      wait_result();
      check("cmp hold", {lowAlarmFlag, highAlarmFlag, alarmIrq}, 3'h3);
      sampleTemp = 16'hff00;
      wait_result();
      check("cmp release", {lowAlarmFlag, highAlarmFlag, alarmIrq}, 3'h0);
      reg_write(8'h2a, 8'h00);
      // pacing for every period code
      latency = 8'h01;
      for (int c = 0; c < 16; c++) begin
         int a;
         int b;
         reg_write(8'h29, 8'(c));
         reg_write(8'h2a, 8'h03);
         wait_start(8, a);
         @(negedge clk);
         wait_start(5000, b);
         check("period", b + 1, period_cycles(c));
         reg_write(8'h2a, 8'h00);
      end
      // stop in mid conversion
      latency = 8'h14;
      reg_write(8'h2a, 8'h03);
      reg_write(8'h2a, 8'h00);
      n = 0;
      while (convAbort !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      check("abort", convAbort, 1'b1);
      n = 0;
      repeat (period_cycles(9) * 4) begin
         @(negedge clk);
         if (convStart === 1'b1) n++;
      end
      check("starts after stop", n, 0);
      reg_read(8'h2a, v);
      check("conv stopped", v[1:0], 2'h0);
      give_verdict();
   end
endmodule

`default_nettype wire

/* File: temp_alarm_defines.svh */
// register offsets, field positions, reset values and timing counts
// for the alarm-style and conversion-period block; definitions only
`ifndef TEMP_ALARM_DEFINES_SVH
`define TEMP_ALARM_DEFINES_SVH

// register offsets on the byte-wide register port
`define TA_STATUS_ADDR    8'h00
`define TA_IRQ_EN_ADDR    8'h02
`define TA_HI_TRIP_ADDR   8'h20
`define TA_LO_TRIP_ADDR   8'h21
`define TA_CFG_ADDR       8'h29
`define TA_CONV_ADDR      8'h2a

// field positions
`define TA_MODE_BIT       7
`define TA_PERIOD_MSB     3
`define TA_LO_FLAG_BIT    3
`define TA_HI_FLAG_BIT    2
`define TA_LO_EN_BIT      3
`define TA_HI_EN_BIT      2
`define TA_TRIP_STYLE_BIT 3
`define TA_AUTO_BIT       1
`define TA_CONVERT_BIT    0

// reset values
`define TA_CFG_RESET      8'h00
`define TA_CONV_RESET     8'h00
`define TA_IRQ_EN_RESET   8'h00
`define TA_TRIP_RESET     8'h00

// timing: shortest period is the base tick, longer ones are powers of two of it
`define TA_BASE_PERIOD_NS 125000000
`define TA_CLK_PERIOD_NS  100
`define TA_BASE_CYCLES    (`TA_BASE_PERIOD_NS / `TA_CLK_PERIOD_NS)
`define TA_CODE_FASTEST   4'h9
`define TA_TICK_CNT_W     10

`endif

/* File: temp_alarm_mode_and_period.sv */
// alarm style selection, threshold alarm flags and autonomous conversion pacing
// assumes the serial engine issues one-cycle register strobes and the
// conversion engine returns one valid pulse per started conversion
`include "temp_alarm_defines.svh"
`default_nettype none

module temp_alarm_mode_and_period #(
   parameter int         TICK_CYCLES = `TA_BASE_CYCLES,
   parameter logic [2:0] TRIP_COUNT  = 3'h1
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // register port from the serial engine
   input  wire temp_alarm_pkg::reg_req_t      regReq,
   output logic [7:0]                         rdData,
   // thresholds and conversion engine
   input  wire logic [15:0]                   hiThreshold,
   input  wire logic [15:0]                   loThreshold,
   input  wire temp_alarm_pkg::conv_result_t  convResult,
   output logic                               convStart,
   output logic                               convAbort,
   // alarm outputs
   output logic                               highAlarmFlag,
   output logic                               lowAlarmFlag,
   output logic                               alarmIrq
);

   temp_alarm_pkg::conv_state_t state_q, state_d;
   logic       mode_q, mode_d;
   logic [3:0] period_q, period_d;
   logic       auto_q, auto_d;
   logic       convertT_q, convertT_d;
   logic       convStart_q, convStart_d;
   logic       convAbort_q, convAbort_d;
   logic       hiEn_q, hiEn_d;
   logic       loEn_q, loEn_d;
   logic       hiTripStyle_q, hiTripStyle_d;
   logic       loTripStyle_q, loTripStyle_d;
   logic       hiFlag_q, hiFlag_d;
   logic       loFlag_q, loFlag_d;
   logic [2:0] hiCnt_q, hiCnt_d;
   logic [2:0] loCnt_q, loCnt_d;
   logic       irq_q, irq_d;
   logic [7:0] rdData_q, rdData_d;
   logic       convWr, cfgWr, statusRead, abortWr, periodTick;
   logic       compMode, sample, hiExceed, loExceed, hiTrip, loTrip;

   // next trip count; consecutive style restarts on a quiet sample
   function automatic logic [2:0] next_count(input logic [2:0] cnt, input logic exceed,
                                             input logic cumulative);
      if (exceed)
         next_count = (cnt == 3'h7) ? cnt : cnt + 3'h1;
      else
         next_count = cumulative ? cnt : 3'h0;
   endfunction
   function automatic logic trip_hit(input logic [2:0] cnt, input logic exceed);
      trip_hit = exceed && ({1'b0, cnt} + 4'h1 >= {1'b0, TRIP_COUNT});
   endfunction

   assign convWr     = regReq.wr && (regReq.addr == `TA_CONV_ADDR);
   assign cfgWr      = regReq.wr && (regReq.addr == `TA_CFG_ADDR);
   assign abortWr    = convWr && !regReq.wdata[`TA_CONVERT_BIT];
   assign statusRead = regReq.rd && (regReq.addr == `TA_STATUS_ADDR);

   period_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_period_timer (
      .clk        (clk),
      .rst_n      (rst_n),
      .run        (state_q != temp_alarm_pkg::CONV_IDLE),
      .periodCode (period_q),
      .periodTick (periodTick)
   );

   // conversion sequencing
   always_comb begin
      state_d     = state_q;
      auto_d      = auto_q;
      convertT_d  = convertT_q;
      convStart_d = 1'b0;
      convAbort_d = 1'b0;
      case (state_q)
         temp_alarm_pkg::CONV_IDLE: begin
            if (convWr) begin
               auto_d = regReq.wdata[`TA_AUTO_BIT];
               if (regReq.wdata[`TA_CONVERT_BIT]) begin
                  convertT_d  = 1'b1;
                  convStart_d = 1'b1;
                  state_d     = temp_alarm_pkg::CONV_BUSY;
               end
            end
         end
         temp_alarm_pkg::CONV_BUSY: begin
            if (abortWr) begin
               auto_d      = regReq.wdata[`TA_AUTO_BIT];
               convertT_d  = 1'b0;
               convAbort_d = 1'b1;
               state_d     = temp_alarm_pkg::CONV_IDLE;
            end else if (convResult.valid) begin
               if (auto_q) begin
                  state_d = temp_alarm_pkg::CONV_PAUSE;
               end else begin
                  convertT_d = 1'b0;
                  state_d    = temp_alarm_pkg::CONV_IDLE;
               end
            end
         end
         temp_alarm_pkg::CONV_PAUSE: begin
            if (abortWr) begin
               auto_d     = regReq.wdata[`TA_AUTO_BIT];
               convertT_d = 1'b0;
               state_d    = temp_alarm_pkg::CONV_IDLE;
            end else if (periodTick) begin
               convStart_d = 1'b1;
               state_d     = temp_alarm_pkg::CONV_BUSY;
            end
         end
         default: begin
            state_d    = temp_alarm_pkg::CONV_IDLE;
            convertT_d = 1'b0;
         end
      endcase
   end

   // configuration and enables
   always_comb begin
      mode_d        = mode_q;
      period_d      = period_q;
      hiEn_d        = hiEn_q;
      loEn_d        = loEn_q;
      hiTripStyle_d = hiTripStyle_q;
      loTripStyle_d = loTripStyle_q;
      if (cfgWr) begin
         mode_d   = regReq.wdata[`TA_MODE_BIT];
         period_d = regReq.wdata[`TA_PERIOD_MSB:0];
      end
      if (regReq.wr && regReq.addr == `TA_IRQ_EN_ADDR) begin
         hiEn_d = regReq.wdata[`TA_HI_EN_BIT];
         loEn_d = regReq.wdata[`TA_LO_EN_BIT];
      end
      if (regReq.wr && regReq.addr == `TA_HI_TRIP_ADDR)
         hiTripStyle_d = regReq.wdata[`TA_TRIP_STYLE_BIT];
      if (regReq.wr && regReq.addr == `TA_LO_TRIP_ADDR)
         loTripStyle_d = regReq.wdata[`TA_TRIP_STYLE_BIT];
   end

   // alarm evaluation
   assign compMode = mode_q && auto_q;
   assign sample   = convResult.valid && (state_q == temp_alarm_pkg::CONV_BUSY) && !abortWr;
   assign hiExceed = $signed(convResult.temp) > $signed(hiThreshold);
   assign loExceed = $signed(convResult.temp) < $signed(loThreshold);
   assign hiTrip   = sample && trip_hit(hiCnt_q, hiExceed);
   assign loTrip   = sample && !compMode && trip_hit(loCnt_q, loExceed);

   always_comb begin
      hiCnt_d = hiCnt_q;
      loCnt_d = loCnt_q;
      if (sample) begin
         hiCnt_d = next_count(hiCnt_q, hiExceed, hiTripStyle_q && !compMode);
         loCnt_d = next_count(loCnt_q, loExceed, loTripStyle_q && !compMode);
      end
      if (compMode) begin
         hiFlag_d = hiTrip || (hiFlag_q && !(sample && loExceed));
         loFlag_d = 1'b0;
         irq_d    = hiFlag_d && hiEn_q;
      end else begin
         hiFlag_d = hiTrip || (hiFlag_q && !statusRead);
         loFlag_d = loTrip || (loFlag_q && !statusRead);
         irq_d    = hiFlag_d || loFlag_d;
      end
   end

   // register read port, answered one cycle after the strobe
   always_comb begin
      rdData_d = rdData_q;
      if (regReq.rd) begin
         case (regReq.addr)
            `TA_CFG_ADDR:     rdData_d = {mode_q, 3'h0, period_q};
            `TA_CONV_ADDR:    rdData_d = {6'h00, auto_q, convertT_q};
            `TA_STATUS_ADDR:  rdData_d = {4'h0, loFlag_q, hiFlag_q, 2'h0};
            `TA_IRQ_EN_ADDR:  rdData_d = {4'h0, loEn_q, hiEn_q, 2'h0};
            `TA_HI_TRIP_ADDR: rdData_d = {4'h0, hiTripStyle_q, 3'h0};
            `TA_LO_TRIP_ADDR: rdData_d = {4'h0, loTripStyle_q, 3'h0};
            default:          rdData_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q       <= temp_alarm_pkg::CONV_IDLE;
         mode_q        <= 1'(`TA_CFG_RESET >> `TA_MODE_BIT);
         period_q      <= 4'h0;
         auto_q        <= 1'b0;
         convertT_q    <= 1'b0;
         convStart_q   <= 1'b0;
         convAbort_q   <= 1'b0;
         hiEn_q        <= 1'b0;
         loEn_q        <= 1'b0;
         hiTripStyle_q <= 1'b0;
         loTripStyle_q <= 1'b0;
         hiFlag_q      <= 1'b0;
         loFlag_q      <= 1'b0;
         hiCnt_q       <= 3'h0;
         loCnt_q       <= 3'h0;
         irq_q         <= 1'b0;
         rdData_q      <= 8'h00;
      end else begin
         state_q       <= state_d;
         mode_q        <= mode_d;
         period_q      <= period_d;
         auto_q        <= auto_d;
         convertT_q    <= convertT_d;
         convStart_q   <= convStart_d;
         convAbort_q   <= convAbort_d;
         hiEn_q        <= hiEn_d;
         loEn_q        <= loEn_d;
         hiTripStyle_q <= hiTripStyle_d;
         loTripStyle_q <= loTripStyle_d;
         hiFlag_q      <= hiFlag_d;
         loFlag_q      <= loFlag_d;
         hiCnt_q       <= hiCnt_d;
         loCnt_q       <= loCnt_d;
         irq_q         <= irq_d;
         rdData_q      <= rdData_d;
      end
   end

   assign rdData        = rdData_q;
   assign convStart     = convStart_q;
   assign convAbort     = convAbort_q;
   assign highAlarmFlag = hiFlag_q;
   assign lowAlarmFlag  = loFlag_q;
   assign alarmIrq      = irq_q;
   property p_reset_cfg;
      @(posedge clk) $rose(rst_n) |-> (!mode_q && period_q == 4'h0);
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config not reset");
   property p_int_irq;
      @(posedge clk) disable iff (!rst_n) (!compMode && (hiTrip || loTrip)) |=> alarmIrq;
   endproperty
   a_int_irq: assert property (p_int_irq) else $error("no irq on crossing");
   property p_read_clears;
      @(posedge clk) disable iff (!rst_n)
         (!compMode && statusRead && !hiTrip && !loTrip) |=> (!hiFlag_q && !loFlag_q);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear");
   property p_comp_irq;
      @(posedge clk) disable iff (!rst_n) compMode && hiTrip && hiEn_q |=> alarmIrq && hiFlag_q;
   endproperty
   a_comp_irq: assert property (p_comp_irq) else $error("no comparator irq");
   property p_hysteresis;
      @(posedge clk) disable iff (!rst_n)
         (compMode && sample && loExceed && !hiTrip) |=> (!hiFlag_q && !alarmIrq);
   endproperty
   a_hysteresis: assert property (p_hysteresis) else $error("flag held below low");
   property p_lo_zero;
      @(posedge clk) disable iff (!rst_n) (compMode && $past(compMode)) |-> !loFlag_q;
   endproperty
   a_lo_zero: assert property (p_lo_zero) else $error("low flag set in comparator");
   property p_comp_read_keeps;
      @(posedge clk) disable iff (!rst_n)
         (compMode && statusRead && hiFlag_q && !(sample && loExceed)) |=> hiFlag_q;
   endproperty
   a_comp_read_keeps: assert property (p_comp_read_keeps) else $error("read cleared");
   property p_consecutive;
      @(posedge clk) disable iff (!rst_n) (compMode && sample && !hiExceed) |=> (hiCnt_q == 3'h0);
   endproperty
   a_consecutive: assert property (p_consecutive) else $error("count not restarted");
   property p_cfg_reserved;
      @(posedge clk) disable iff (!rst_n)
         (regReq.rd && regReq.addr == `TA_CFG_ADDR) |=> (rdData[6:4] == 3'h0);
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved bits set");
   property p_auto_repeat;
      @(posedge clk) disable iff (!rst_n)
         (state_q == temp_alarm_pkg::CONV_PAUSE && periodTick && !abortWr)
            |=> (convStart && convertT_q) ##1 !convStart;
   endproperty
   a_auto_repeat: assert property (p_auto_repeat) else $error("no repeat start");

endmodule

`default_nettype wire

/* File: temp_alarm_pkg.sv */
// types shared by the alarm-style and conversion-period block
// assumes the defines header for all numeric constants
`default_nettype none

package temp_alarm_pkg;

   // one access on the register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // result handed back by the conversion engine
   typedef struct packed {
      logic        valid;
      logic [15:0] temp;
   } conv_result_t;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_BUSY,
      CONV_PAUSE
   } conv_state_t;

endpackage

`default_nettype wire
